// ### logic/mmdec_top.sv
module mmdec_top #(
	parameter int sram_max_kb = 96 // Largest SRAM fitted
) (
	input  wire logic        pclk,       // System clock, 10 MHz
	input  wire logic        presetn,    // Async reset, active low
	input  wire logic        psel,       // APB select
	input  wire logic        penable,    // APB access phase
	input  wire logic        pwrite,     // APB direction
	input  wire logic [11:0] paddr,      // APB byte address
	input  wire logic [31:0] pwdata,     // APB write data
	output logic [31:0]      prdata,     // APB read data
	output logic             pready,     // APB ready
	output logic             pslverr,    // APB error
	input  wire logic        boot_nv,    // Non-volatile boot bit
	input  wire logic        bus_req,    // System bus address valid
	input  wire logic [31:0] bus_addr,   // System bus address
	input  wire logic        bus_write,  // System bus write
	input  wire logic        bus_cpu,    // Master is the CPU
	output mmdec_pkg::mmdec_tgt_t sel_tgt, // Selected target
	output logic [31:0]      sel_offset, // Offset in target
	output logic             sel_tcm,    // Tightly-coupled path
	output logic             sel_buf,    // Buffered write
	output logic             sel_err     // Bus error response
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [1:0]  sram_size;
		logic [31:0] bank0_start;
		logic [31:0] bank0_size;
		logic [31:0] bank1_start;
		logic [31:0] bank1_size;
		logic        bank0_en;
		logic        bank1_en;
		logic        wbuf_en;
		logic        booted;   // Boot layout applied
		logic [31:0] rdata;
		logic        err_seen; // Sticky decode error
	} mmdec_regs_t;

	mmdec_regs_t st;      // Current registers
	mmdec_regs_t next_st; // Next registers

	mmdec_cfg_if cfg ();  // Config to decoder
	logic boot_sel;       // Captured strap
	logic boot_vld;       // Strap captured
	logic acc;            // APB access phase
	logic map_hit;        // Address mapped

	// ****************************************************************
	// Strap capture and decoder
	// ****************************************************************
	mmdec_strap u_strap (
		.pclk     (pclk),
		.presetn  (presetn),
		.boot_nv  (boot_nv),
		.boot_sel (boot_sel),
		.boot_vld (boot_vld)
	);

	mmdec_decode #(.sram_max_kb(sram_max_kb)) u_dec (
		.pclk     (pclk),
		.presetn  (presetn),
		.cfg      (cfg),
		.req      (bus_req),
		.addr     (bus_addr),
		.write    (bus_write),
		.from_cpu (bus_cpu),
		.tgt      (sel_tgt),
		.offset   (sel_offset),
		.tcm      (sel_tcm),
		.buffered (sel_buf),
		.err      (sel_err)
	);

	// Drive configuration out
	assign cfg.sram_size   = st.sram_size;
	assign cfg.bank0_start = st.bank0_start;
	assign cfg.bank0_size  = st.bank0_size;
	assign cfg.bank1_start = st.bank1_start;
	assign cfg.bank1_size  = st.bank1_size;
	assign cfg.bank0_en    = st.bank0_en;
	assign cfg.bank1_en    = st.bank1_en;
	assign cfg.wbuf_en     = st.wbuf_en;

	// ****************************************************************
	// APB slave
	// ****************************************************************
	assign acc = psel && penable;
	assign map_hit = (paddr[1:0] == 2'h0) && (paddr <= mmdec_pkg::off_status);
	assign pready = 1'b1;            // Zero wait states
	assign pslverr = acc && !map_hit; // Unmapped address
	assign prdata = st.rdata;

	// Register update, read mux and boot layout
	always_comb begin
		next_st = st;
		// Apply boot layout once strap is known
		if (boot_vld && !st.booted) begin
			next_st.booted = 1'b1;
			if (boot_sel) begin
				next_st.bank1_en = 1'b1;
				next_st.bank1_start = mmdec_pkg::boot_base;
				next_st.bank1_size = mmdec_pkg::boot_size;
			end else begin
				next_st.bank0_en = 1'b1;
				next_st.bank0_start = mmdec_pkg::boot_base;
				next_st.bank0_size = mmdec_pkg::boot_size;
			end
		end
		// Error flag: set wins over read-clear
		if (psel && !penable && !pwrite
			&& paddr == mmdec_pkg::off_status) begin
			next_st.err_seen = 1'b0;
		end
		if (sel_err) begin
			next_st.err_seen = 1'b1;
		end
		// Read data prepared in setup phase
		if (psel && !penable) begin
			next_st.rdata = '0;
			unique case (paddr)
				mmdec_pkg::off_sram_size:
					next_st.rdata = {30'h0000_0000, st.sram_size};
				mmdec_pkg::off_bank0_start:
					next_st.rdata = st.bank0_start;
				mmdec_pkg::off_bank0_size:
					next_st.rdata = st.bank0_size;
				mmdec_pkg::off_bank1_start:
					next_st.rdata = st.bank1_start;
				mmdec_pkg::off_bank1_size:
					next_st.rdata = st.bank1_size;
				mmdec_pkg::off_bank_ctrl: begin
					next_st.rdata[mmdec_pkg::bit_bank0_en] = st.bank0_en;
					next_st.rdata[mmdec_pkg::bit_bank1_en] = st.bank1_en;
					next_st.rdata[mmdec_pkg::bit_boot_sel] = boot_sel;
				end
				mmdec_pkg::off_wbuf_ctrl:
					next_st.rdata[mmdec_pkg::bit_wbuf_en] = st.wbuf_en;
				mmdec_pkg::off_status: begin
					next_st.rdata[0] = st.err_seen;
					next_st.rdata[1] = boot_vld;
				end
				default: next_st.rdata = '0;
			endcase
		end
		// Writes in access phase
		if (acc && pwrite) begin
			unique case (paddr)
				mmdec_pkg::off_sram_size: begin
					if (pwdata[1:0] == mmdec_pkg::sram_32k
						|| pwdata[1:0] == mmdec_pkg::sram_64k
						|| (pwdata[1:0] == mmdec_pkg::sram_96k
						&& sram_max_kb == 96))
						next_st.sram_size = pwdata[1:0];
				end
				mmdec_pkg::off_bank0_start:
					next_st.bank0_start = pwdata;
				mmdec_pkg::off_bank0_size:
					next_st.bank0_size = pwdata;
				mmdec_pkg::off_bank1_start:
					next_st.bank1_start = pwdata;
				mmdec_pkg::off_bank1_size:
					next_st.bank1_size = pwdata;
				mmdec_pkg::off_bank_ctrl: begin    // boot bit RO
					next_st.bank0_en = pwdata[mmdec_pkg::bit_bank0_en];
					next_st.bank1_en = pwdata[mmdec_pkg::bit_bank1_en];
				end
				mmdec_pkg::off_wbuf_ctrl:
					next_st.wbuf_en = pwdata[mmdec_pkg::bit_wbuf_en];
				default: begin
				end
			endcase
		end
	end

	// Register bank; size 32K, buffering off, banks off till strap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule : mmdec_top

// ### logic/mmdec_pkg.sv
package mmdec_pkg;

	// ****************************************************************
	// Register offsets (byte addresses on the APB slave)
	// ****************************************************************
	localparam logic [11:0] off_sram_size   = 12'h000; // SRAM size code
	localparam logic [11:0] off_bank0_start = 12'h004; // Primary bank base
	localparam logic [11:0] off_bank0_size  = 12'h008; // Primary bank size
	localparam logic [11:0] off_bank1_start = 12'h00c; // Secondary base
	localparam logic [11:0] off_bank1_size  = 12'h010; // Secondary size
	localparam logic [11:0] off_bank_ctrl   = 12'h014; // Enables, boot
	localparam logic [11:0] off_wbuf_ctrl   = 12'h018; // Buffered writes
	localparam logic [11:0] off_status      = 12'h01c; // Decode status

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int bit_bank0_en  = 0; // Bank control: primary enable
	localparam int bit_bank1_en  = 1; // Bank control: secondary enable
	localparam int bit_boot_sel  = 2; // Bank control: boot strap (RO)
	localparam int bit_wbuf_en   = 3; // Write-buffer enable position
	localparam logic [1:0] sram_32k = 2'h0; // Size code 32K
	localparam logic [1:0] sram_64k = 2'h1; // Size code 64K
	localparam logic [1:0] sram_96k = 2'h2; // Size code 96K
	localparam logic [31:0] boot_base     = 32'h0000_0000; // Boot address
	localparam logic [31:0] boot_size     = 32'h0001_0000; // First sector
	localparam logic [31:0] sram_kbyte    = 32'h0000_0400; // One kilobyte

	// ****************************************************************
	// Window bases
	// ****************************************************************
	localparam logic [31:0] tcm_sram_base   = 32'h0400_0000; // TCM alias
	localparam logic [31:0] buf_sram_base   = 32'h4000_0000; // Buffered
	localparam logic [31:0] nbuf_sram_base  = 32'h5000_0000; // Direct
	localparam logic [31:0] buf_periph_lo   = 32'h4800_0000; // Bridges buf
	localparam logic [31:0] buf_periph_hi   = 32'h4fff_ffff;
	localparam logic [31:0] nbuf_periph_lo  = 32'h5800_0000; // Bridges nbuf
	localparam logic [31:0] nbuf_periph_hi  = 32'h5fff_ffff;
	localparam logic [31:0] bridge_b_offset = 32'h0400_0000; // Second half

	// ****************************************************************
	// Targets
	// ****************************************************************
	typedef enum logic [2:0] {
		mmdec_tgt_none   = 3'b000,
		mmdec_tgt_sram   = 3'b001,
		mmdec_tgt_flash0 = 3'b010,
		mmdec_tgt_flash1 = 3'b011,
		mmdec_tgt_brg_a  = 3'b100,
		mmdec_tgt_brg_b  = 3'b101
	} mmdec_tgt_t;

endpackage : mmdec_pkg

// ### logic/mmdec_cfg_if.sv
// Configuration handed from the register file to the decoder
interface mmdec_cfg_if;
	logic [1:0]  sram_size;   // SRAM size code
	logic [31:0] bank0_start; // Primary bank base
	logic [31:0] bank0_size;  // Primary bank size in bytes
	logic [31:0] bank1_start; // Secondary bank base
	logic [31:0] bank1_size;  // Secondary bank size in bytes
	logic        bank0_en;    // Primary bank enable
	logic        bank1_en;    // Secondary bank enable
	logic        wbuf_en;     // Buffered writes allowed

	modport regs (output sram_size, bank0_start, bank0_size,
		bank1_start, bank1_size, bank0_en, bank1_en, wbuf_en);
	modport dec (input sram_size, bank0_start, bank0_size,
		bank1_start, bank1_size, bank0_en, bank1_en, wbuf_en);
endinterface : mmdec_cfg_if

// ### logic/mmdec_strap.sv
// ********************************************************************
// Boot strap capture: three-stage synchroniser on the config bit
// ********************************************************************
module mmdec_strap (
	input  wire logic pclk,     // System clock
	input  wire logic presetn,  // Async reset, active low
	input  wire logic boot_nv,  // Non-volatile boot bit from flash
	output logic      boot_sel, // Captured boot selection
	output logic      boot_vld  // Capture done
);
	typedef struct packed {
		logic [2:0] sync;  // Three-flop synchroniser
		logic       sel;   // Latched choice
		logic       vld;   // Capture done
		logic [1:0] fill;  // Edges seen since reset release
	} mmdec_strap_t;

	mmdec_strap_t st;      // Current state
	mmdec_strap_t next_st; // Next state

	// Capture once after release; CPU has no path to change it
	always_comb begin
		next_st = st;
		next_st.sync = {st.sync[1:0], boot_nv};
		// Reset zeros in the chain must not pass for a real sample
		if (!(&st.fill)) begin
			next_st.fill = st.fill + 2'h1;
		end
		if (!st.vld && (&st.fill)
			&& (st.sync[2] == st.sync[1])) begin
			next_st.sel = st.sync[2];
			next_st.vld = 1'b1;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign boot_sel = st.sel;
	assign boot_vld = st.vld;
endmodule : mmdec_strap

// ### logic/mmdec_decode.sv
// ********************************************************************
// Address decoder core (combinational plus registered outputs)
// ********************************************************************
module mmdec_decode #(
	parameter int sram_max_kb = 96 // Largest SRAM fitted
) (
	input  wire logic     pclk,      // System clock
	input  wire logic     presetn,   // Async reset, active low
	mmdec_cfg_if.dec      cfg,       // Decode configuration
	input  wire logic     req,       // Address phase valid
	input  wire logic [31:0] addr,   // Bus address
	input  wire logic     write,     // Write access
	input  wire logic     from_cpu,  // Master is the CPU
	output mmdec_pkg::mmdec_tgt_t tgt, // Selected target
	output logic [31:0]   offset,    // Offset inside target
	output logic          tcm,       // Via tightly-coupled port
	output logic          buffered,  // Write may be buffered
	output logic          err        // No window hit
);
	// Refuse SRAM sizes the decoder cannot map
	if (sram_max_kb != 64 && sram_max_kb != 96) begin : g_bad_sram
		$error("sram_max_kb must be 64 or 96");
	end

	typedef struct packed {
		mmdec_pkg::mmdec_tgt_t tgt;
		logic [31:0] offset;
		logic        tcm;
		logic        buffered;
		logic        err;
	} mmdec_dec_t;

	mmdec_dec_t st;      // Registered result
	mmdec_dec_t next_st; // Decoded result

	// Window hit test, used for the SRAM aliases and flash banks
	function automatic logic in_win(input logic [31:0] a,
		input logic [31:0] base, input logic [31:0] size);
		logic [31:0] d;
		d = a - base;
		in_win = (a >= base) && (d < size);
	endfunction : in_win

	// SRAM bytes from size code; 96K only when fitted, other codes give 32K
	function automatic logic [31:0] sram_bytes(input logic [1:0] c);
		logic [31:0] b;
		b = mmdec_pkg::sram_kbyte << 5;
		if (c == mmdec_pkg::sram_64k)
			b = mmdec_pkg::sram_kbyte << 6;
		if (c == mmdec_pkg::sram_96k && sram_max_kb == 96)
			b = mmdec_pkg::sram_kbyte * 32'd96;
		sram_bytes = b;
	endfunction : sram_bytes

	logic [31:0] sram_len; // Active SRAM window length

	// Decode one address against every window
	always_comb begin
		sram_len = sram_bytes(cfg.sram_size);
		next_st = '0;
		next_st.tgt = mmdec_pkg::mmdec_tgt_none;
		if (req) begin
			if (in_win(addr, mmdec_pkg::tcm_sram_base, sram_len)) begin
				next_st.tgt = mmdec_pkg::mmdec_tgt_sram;
				next_st.offset = addr - mmdec_pkg::tcm_sram_base;
				next_st.tcm = from_cpu;
			end else if (in_win(addr, mmdec_pkg::buf_sram_base,
				sram_len)) begin
				next_st.tgt = mmdec_pkg::mmdec_tgt_sram;
				next_st.offset = addr - mmdec_pkg::buf_sram_base;
				// Only CPU writes with buffering on
				next_st.buffered = from_cpu && write
					&& cfg.wbuf_en;
			end else if (in_win(addr, mmdec_pkg::nbuf_sram_base,
				sram_len)) begin
				next_st.tgt = mmdec_pkg::mmdec_tgt_sram;
				next_st.offset = addr - mmdec_pkg::nbuf_sram_base;
			end else if (addr >= mmdec_pkg::buf_periph_lo
				&& addr <= mmdec_pkg::buf_periph_hi) begin
				next_st.offset = addr - mmdec_pkg::buf_periph_lo;
				next_st.buffered = from_cpu && write && cfg.wbuf_en;
			end else if (addr >= mmdec_pkg::nbuf_periph_lo
				&& addr <= mmdec_pkg::nbuf_periph_hi) begin
				next_st.offset = addr - mmdec_pkg::nbuf_periph_lo;
			end else if (cfg.bank0_en && in_win(addr, cfg.bank0_start,
				cfg.bank0_size)) begin
				next_st.tgt = mmdec_pkg::mmdec_tgt_flash0;
				next_st.offset = addr - cfg.bank0_start;
			end else if (cfg.bank1_en && in_win(addr, cfg.bank1_start,
				cfg.bank1_size)) begin
				next_st.tgt = mmdec_pkg::mmdec_tgt_flash1;
				next_st.offset = addr - cfg.bank1_start;
			end else begin
				next_st.err = 1'b1;
			end
			// Split bridge range into its two windows
			if (((addr >= mmdec_pkg::buf_periph_lo
				&& addr <= mmdec_pkg::buf_periph_hi)
				|| (addr >= mmdec_pkg::nbuf_periph_lo
				&& addr <= mmdec_pkg::nbuf_periph_hi))
				&& next_st.tgt == mmdec_pkg::mmdec_tgt_none
				&& !next_st.err) begin
				if (next_st.offset < mmdec_pkg::bridge_b_offset) begin
					next_st.tgt = mmdec_pkg::mmdec_tgt_brg_a;
				end else begin
					next_st.tgt = mmdec_pkg::mmdec_tgt_brg_b;
					next_st.offset = next_st.offset
						- mmdec_pkg::bridge_b_offset;
				end
			end
		end
	end

	// Result register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tgt      = st.tgt;
	assign offset   = st.offset;
	assign tcm      = st.tcm;
	assign buffered = st.buffered;
	assign err      = st.err;
endmodule : mmdec_decode

// ### test/mmdec_properties.sv
// ********************************************************************
// Decode checker on the top module ports
// ********************************************************************
module mmdec_properties #(
	parameter int sram_max_kb = 96 // Largest SRAM fitted
) (
	input logic                  pclk,       // System clock
	input logic                  presetn,    // Async reset, active low
	input logic                  psel,       // APB select
	input logic                  penable,    // APB access phase
	input logic                  pwrite,     // APB direction
	input logic [11:0]           paddr,      // APB address
	input logic [31:0]           pwdata,     // APB write data
	input logic [31:0]           prdata,     // APB read data
	input logic                  pready,     // APB ready
	input logic                  pslverr,    // APB error
	input logic                  boot_nv,    // Boot bit
	input logic                  bus_req,    // Address valid
	input logic [31:0]           bus_addr,   // Address
	input logic                  bus_write,  // Write access
	input logic                  bus_cpu,    // CPU master
	input mmdec_pkg::mmdec_tgt_t sel_tgt,    // Target
	input logic [31:0]           sel_offset, // Offset in target
	input logic                  sel_tcm,    // Coupled path
	input logic                  sel_buf,    // Buffered write
	input logic                  sel_err     // Bus error
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Request from a master other than the CPU
	sequence s_dma_req;
		bus_req && !bus_cpu;
	endsequence
	// Request inside the smallest SRAM size of an alias
	sequence s_sram_hit(logic [31:0] base);
		bus_req && bus_addr >= base && bus_addr < base + 32'h0000_8000;
	endsequence

	chk_idle_no_target: assert property (
		!bus_req |=> sel_tgt == mmdec_pkg::mmdec_tgt_none && !sel_err)
		else $error("target selected without request");
	chk_tcm_cpu_path: assert property (
		s_sram_hit(32'h0400_0000) ##0 bus_cpu
		|=> sel_tcm && sel_tgt == mmdec_pkg::mmdec_tgt_sram)
		else $error("cpu coupled alias not on coupled path");
	chk_tcm_dma_bus: assert property (
		s_dma_req |=> !sel_tcm)
		else $error("other master sent to coupled path");
	chk_dma_no_buf: assert property (
		s_dma_req |=> !sel_buf)
		else $error("other master write buffered");
	chk_read_direct: assert property (
		bus_req && !bus_write |=> !sel_buf)
		else $error("read marked buffered");
	chk_direct_sram: assert property (
		s_sram_hit(32'h5000_0000) |=> sel_tgt == mmdec_pkg::mmdec_tgt_sram
		&& !sel_buf && sel_offset == $past(bus_addr) - 32'h5000_0000)
		else $error("direct sram alias wrong");
	chk_bridge_a_offset: assert property (
		bus_req && bus_addr[31:26] == 6'h12
		|=> sel_tgt == mmdec_pkg::mmdec_tgt_brg_a
		&& sel_offset == $past(bus_addr) - 32'h4800_0000)
		else $error("bridge a window wrong");
	chk_bridge_b_direct: assert property (
		bus_req && bus_addr[31:26] == 6'h17
		|=> sel_tgt == mmdec_pkg::mmdec_tgt_brg_b && !sel_buf
		&& sel_offset == $past(bus_addr) - 32'h5c00_0000)
		else $error("direct bridge b window wrong");
	chk_err_no_target: assert property (
		sel_err |-> sel_tgt == mmdec_pkg::mmdec_tgt_none && !sel_buf)
		else $error("error with a target selected");
endmodule : mmdec_properties

// ### test/mmdec_bus_master.sv
// ********************************************************************
// System bus master model: one address phase per call
// ********************************************************************
module mmdec_bus_master (
	input  wire logic pclk,      // System clock
	output logic      bus_req,   // Address valid
	output logic [31:0] bus_addr, // Address
	output logic      bus_write, // Write access
	output logic      bus_cpu    // CPU master
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle at time zero
	initial begin
		bus_req = 1'b0;
		bus_addr = 32'h0000_0000;
		bus_write = 1'b0;
		bus_cpu = 1'b0;
	end
	// Drive one request, then release with inverted qualifiers
	task automatic access(input logic [31:0] a, input logic w,
		input logic c);
		@(posedge pclk);
		bus_req <= 1'b1;
		bus_addr <= a;
		bus_write <= w;
		bus_cpu <= c;
		@(posedge pclk);
		bus_req <= 1'b0;
		bus_addr <= ~a;
		bus_write <= ~w;
		bus_cpu <= ~c;
	endtask : access
endmodule : mmdec_bus_master

// ### test/tb.sv
// ********************************************************************
// Testbench top
// ********************************************************************
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int sram_max_kb = 96; // Larger SRAM part
	logic        pclk;       // System clock
	logic        presetn;    // Reset, active low
	logic        psel;       // APB select
	logic        penable;    // APB access phase
	logic        pwrite;     // APB direction
	logic [11:0] paddr;      // APB address
	logic [31:0] pwdata;     // APB write data
	logic [31:0] prdata;     // APB read data
	logic        pready;     // APB ready
	logic        pslverr;    // APB error
	logic        boot_nv;    // Boot bank bit
	logic        bus_req;    // Address valid
	logic [31:0] bus_addr;   // Address
	logic        bus_write;  // Write access
	logic        bus_cpu;    // CPU master
	mmdec_pkg::mmdec_tgt_t sel_tgt; // Target
	logic [31:0] sel_offset; // Offset
	logic        sel_tcm;    // Coupled path
	logic        sel_buf;    // Buffered
	logic        sel_err;    // Bus error
	int          error_cnt;  // Mismatches
	int          cmp_count;  // Comparisons
	logic [31:0] q;          // Read data
	logic        e;          // Error flag

	mmdec_top #(.sram_max_kb(sram_max_kb)) mmdec_top_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.boot_nv(boot_nv), .bus_req(bus_req), .bus_addr(bus_addr),
		.bus_write(bus_write), .bus_cpu(bus_cpu), .sel_tgt(sel_tgt),
		.sel_offset(sel_offset), .sel_tcm(sel_tcm), .sel_buf(sel_buf),
		.sel_err(sel_err));
	mmdec_bus_master mmdec_bus_master_inst (.pclk(pclk),
		.bus_req(bus_req), .bus_addr(bus_addr), .bus_write(bus_write),
		.bus_cpu(bus_cpu));

	// Clock, 100 ns period
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// Compare and count
	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] x);
		cmp_count++;
		if (s !== x) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	// Counts and verdict
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	// One APB transfer, waits for pready under a bound
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin
			error_cnt++;
			report_and_stop();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Read and compare a register
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		chk("prdata", q, x);
	endtask : rd
	// One decode with expected target, offset, path and buffering
	task automatic dec(input logic [31:0] a, input logic w, input logic c,
		input mmdec_pkg::mmdec_tgt_t t, input logic [31:0] o,
		input logic tc, input logic bf);
		mmdec_bus_master_inst.access(a, w, c);
		@(negedge pclk);
		chk("sel_tgt", {29'h0, sel_tgt}, {29'h0, t});
		if (t != mmdec_pkg::mmdec_tgt_none) chk("sel_offset", sel_offset, o);
		chk("sel_tcm", {31'h0, sel_tcm}, {31'h0, tc});
		chk("sel_buf", {31'h0, sel_buf}, {31'h0, bf});
		chk("sel_err", {31'h0, sel_err},
			{31'h0, t == mmdec_pkg::mmdec_tgt_none});
	endtask : dec
	// Reset for 16 cycles, then let the strap settle
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask : do_reset

	// Main sequence
	initial begin
		logic [31:0] ba [4];
		logic [31:0] lo;
		int i;
		ba = '{32'h4800_0100, 32'h4c00_0040, 32'h5800_0100, 32'h5fff_fffc};
		error_cnt = 0;
		cmp_count = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		boot_nv = 1'b0;
		do_reset();
		rd(mmdec_pkg::off_bank_ctrl, 32'h0000_0001);
		rd(mmdec_pkg::off_sram_size, 32'h0000_0000);
		rd(mmdec_pkg::off_wbuf_ctrl, 32'h0000_0000);
		dec(32'h0000_fffc, 0, 1, mmdec_pkg::mmdec_tgt_flash0,
			32'h0000_fffc, 0, 0);
		dec(32'h0001_0000, 0, 1, mmdec_pkg::mmdec_tgt_none, 0, 0, 0);
		$display("test boot_default done");
		dec(32'h5000_7ffc, 0, 1, mmdec_pkg::mmdec_tgt_sram,
			32'h0000_7ffc, 0, 0);
		dec(32'h5000_8000, 0, 1, mmdec_pkg::mmdec_tgt_none, 0, 0, 0);
		for (i = 1; i < 3; i++) begin
			apb(1'b1, mmdec_pkg::off_sram_size, i);
			lo = (i + 1) * 32'h0000_8000;
			dec(32'h5000_0000 + lo - 4, 0, 1, mmdec_pkg::mmdec_tgt_sram,
				lo - 4, 0, 0);
			dec(32'h5000_0000 + lo, 0, 1, mmdec_pkg::mmdec_tgt_none,
				0, 0, 0);
		end
		apb(1'b1, mmdec_pkg::off_sram_size, 32'h0000_0003);
		rd(mmdec_pkg::off_sram_size, 32'h0000_0002);
		$display("test sram_size done");
		dec(32'h0400_0010, 1, 1, mmdec_pkg::mmdec_tgt_sram, 32'h10, 1, 0);
		dec(32'h0400_0010, 1, 0, mmdec_pkg::mmdec_tgt_sram, 32'h10, 0, 0);
		dec(32'h4000_0010, 1, 1, mmdec_pkg::mmdec_tgt_sram, 32'h10, 0, 0);
		apb(1'b1, mmdec_pkg::off_wbuf_ctrl, 32'h0000_0008);
		dec(32'h4000_0010, 1, 1, mmdec_pkg::mmdec_tgt_sram, 32'h10, 0, 1);
		dec(32'h4000_0010, 0, 1, mmdec_pkg::mmdec_tgt_sram, 32'h10, 0, 0);
		dec(32'h4000_0010, 1, 0, mmdec_pkg::mmdec_tgt_sram, 32'h10, 0, 0);
		dec(32'h5000_0010, 1, 1, mmdec_pkg::mmdec_tgt_sram, 32'h10, 0, 0);
		$display("test sram_alias done");
		for (i = 0; i < 4; i++) begin
			lo = (ba[i] < 32'h5800_0000) ? 32'h4800_0000 : 32'h5800_0000;
			dec(ba[i], 1, 1, ba[i][26] ? mmdec_pkg::mmdec_tgt_brg_b
				: mmdec_pkg::mmdec_tgt_brg_a,
				ba[i] - lo - (ba[i][26] ? 32'h0400_0000 : 32'h0),
				0, lo == 32'h4800_0000);
		end
		$display("test bridges done");
		apb(1'b1, mmdec_pkg::off_bank0_start, 32'h0000_0000);
		apb(1'b1, mmdec_pkg::off_bank0_size, 32'h0000_8000);
		apb(1'b1, mmdec_pkg::off_bank1_start, 32'h0000_8000);
		apb(1'b1, mmdec_pkg::off_bank1_size, 32'h0000_4000);
		apb(1'b1, mmdec_pkg::off_bank_ctrl, 32'h0000_0007);
		rd(mmdec_pkg::off_bank_ctrl, 32'h0000_0003);
		dec(32'h0000_7ffc, 0, 1, mmdec_pkg::mmdec_tgt_flash0,
			32'h0000_7ffc, 0, 0);
		dec(32'h0000_8010, 1, 1, mmdec_pkg::mmdec_tgt_flash1,
			32'h0000_0010, 0, 0);
		dec(32'h0000_c000, 0, 1, mmdec_pkg::mmdec_tgt_none, 0, 0, 0);
		apb(1'b1, 12'h020, 32'h0000_0001);
		chk("pslverr", {31'h0, e}, 32'h0000_0001);
		rd(mmdec_pkg::off_status, 32'h0000_0003);
		rd(mmdec_pkg::off_status, 32'h0000_0002);
		$display("test flash_banks done");
		boot_nv <= 1'b1;
		do_reset();
		rd(mmdec_pkg::off_bank_ctrl, 32'h0000_0006);
		dec(32'h0000_0010, 0, 1, mmdec_pkg::mmdec_tgt_flash1,
			32'h0000_0010, 0, 0);
		do_reset();
		rd(mmdec_pkg::off_bank_ctrl, 32'h0000_0006);
		$display("test boot_alternate done");
		report_and_stop();
	end
endmodule : tb

bind mmdec_top mmdec_properties #(.sram_max_kb(sram_max_kb))
	mmdec_properties_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.boot_nv(boot_nv), .bus_req(bus_req), .bus_addr(bus_addr),
	.bus_write(bus_write), .bus_cpu(bus_cpu), .sel_tgt(sel_tgt),
	.sel_offset(sel_offset), .sel_tcm(sel_tcm), .sel_buf(sel_buf),
	.sel_err(sel_err));
